// ---- bench/ipc_coil_model.sv ----
// coil current sense model answering while the bridge switches
`timescale 1ns/100ps
`default_nettype none
module ipc_coil_model (
  input  wire logic        i_clk_sys,
  input  wire logic        i_drive_a,
  input  wire logic        i_drive_b,
  input  wire logic [11:0] i_level,
  output var  logic [11:0] o_coil_ma
);
  int   idle = 1000;
  logic last_a = 1'b0;
  logic last_b = 1'b0;
  always @(posedge i_clk_sys) begin
    idle   <= (i_drive_a != last_a || i_drive_b != last_b) ? 0 : idle + 1;
    last_a <= i_drive_a;
    last_b <= i_drive_b;
  end
  // a silent bridge carries no coil current, so the sense reads zero
  always_comb begin
    o_coil_ma = (idle < 200) ? i_level : 12'h000;
  end
endmodule : ipc_coil_model
`default_nettype wire

// ---- bench/tb_inductive_tx_power_pid_control.sv ----
// self-checking bench of the pid power controller against a loop model
`timescale 1ns/100ps
`default_nettype none
module tb_inductive_tx_power_pid_control;
  import ipc_pkg::*;
  localparam int TK = 20;
  logic        clk, rstn, psel, penable, pwrite, pready, pslverr, da, db, e;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic [11:0] coil, level;
  int          fails, n_tests, tgt, mf, md, mi, mo, k, na, ha;
  bit          dm;
  logic        pa;
  ipc_power_ctrl #(.P_TICK_CYCLES(TK)) uut (.i_clk_sys(clk), .i_rstn(rstn),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .i_coil_ma(coil), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .o_drive_a(da), .o_drive_b(db));
  ipc_coil_model cm (.i_clk_sys(clk), .i_drive_a(da), .i_drive_b(db),
    .i_level(level), .o_coil_ma(coil));
  always #50 clk = ~clk;
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_tests++;
    if (g !== x) begin
      fails++;
      $display("ERROR %0t: got %0h expected %0h", $time, g, x);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) chk(32'h0000_0000, 32'h0000_0001);
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0000_0000);
    chk(q, x);
    chk({31'h0, e}, 32'h0000_0000);
  endtask : rd
  function automatic int sat(input int v, input int m);
    return v > m ? m : (v < -m ? -m : v);
  endfunction : sat
  // one loop update; integral kept in twentieths so gain 0.05 stays exact
  task automatic step();
    int er, sc;
    er = tgt - int'(level);
    mi = sat(mi + er, 60000);
    mo = sat(10 * er + mi / 20, 20000);
    if (dm) begin
      md = md + mo;
      if (md < 1000) md = 1000;
      if (md >= 5000) begin
        md = 5000;
        dm = 0;
      end
    end else begin
      sc = mf < 280000 ? 3 : mf < 320000 ? 4 : mf < 360000 ? 6 : 10;
      mf = mf - mo * sc;
      if (mf < 220000) mf = 220000;
      if (mf > 410000) begin
        mf = 410000;
        dm = mo < 0;
      end
    end
  endtask : step
  // tick count while running is not exact, so walk the model up to the
  // design's state and demand that every observable agrees
  task automatic sync();
    logic [31:0] f, d, s;
    apb(1'b0, REG_FREQ, 32'h0000_0000);
    f = q;
    apb(1'b0, REG_DUTY, 32'h0000_0000);
    d = q;
    apb(1'b0, REG_STATUS, 32'h0000_0000);
    s = q;
    apb(1'b0, REG_LOOP_OUT, 32'h0000_0000);
    for (k = 0; k < 60; k++) begin
      if (mf == f && md == d && dm == s[0] && mo == q) break;
      step();
    end
    chk(f, mf);
    chk(d, md);
    chk({31'h0, s[0]}, {31'h0, dm});
    chk(q, mo);
  endtask : sync
  always @(posedge clk) if (da === 1'b1 && db === 1'b1) chk(32'h0, 32'h1);
  always @(posedge clk) begin
    pa <= da;
    na <= na + int'(da && !pa);
    ha <= ha + int'(da);
  end
  // window cuts a period: one edge or one high time of slack
  task automatic drive_rate(input int f, input int d);
    int n0, h0;
    n0 = na;
    h0 = ha;
    repeat (2000) @(posedge clk);
    n_tests++;
    if (na - n0 > f / 10000 + 1 || na - n0 < f / 10000 - 1) begin
      fails++;
      $display("ERROR %0t: %0d drive periods", $time, na - n0);
    end
    n_tests++;
    if (ha - h0 > d / 5 + 50 || ha - h0 < d / 5 - 50) begin
      fails++;
      $display("ERROR %0t: %0d drive high cycles", $time, ha - h0);
    end
  endtask : drive_rate
  initial begin
    #(100 * 40000);
    fails++;
    conclude();
  end
  initial begin
    clk     = 1'b0;
    rstn    = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0000_0000;
    level   = 12'h000;
    void'($urandom(32'hd031));
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    rd(REG_CTRL, 32'h0000_0000);
    rd(REG_FREQ, 32'h0005_5730);
    rd(REG_DUTY, 32'h0000_1388);
    rd(REG_STATUS, 32'h0000_0000);
    apb(1'b1, REG_FREQ, 32'h0000_0001);
    rd(REG_FREQ, 32'h0005_5730);
    apb(1'b0, 8'h1c, 32'h0000_0000);
    chk({31'h0, e}, 32'h0000_0001);
    chk(q, 32'h0000_0000);
    $display("test registers done");
    level <= 12'($urandom_range(2900, 1100));
    apb(1'b1, REG_CTRL, 32'h0000_0001);
    rd(REG_FREQ, 32'h0005_5730);
    repeat (300) @(posedge clk);
    rd(REG_COIL, {20'h0, level});
    rd(REG_STATUS, 32'h0000_0002);
    $display("test power up done");
    mf = 350000;
    md = 5000;
    mi = 0;
    mo = 0;
    dm = 0;
    for (int p = 0; p < 6; p++) begin
      tgt = int'(level) + ((p == 0 || p > 3) ? 20 : -20) *
            int'($urandom_range(50, 25));
      apb(1'b1, REG_TARGET, 32'(tgt));
      apb(1'b1, REG_CTRL, 32'h0000_0003);
      repeat (40 * TK) @(posedge clk);
      apb(1'b1, REG_CTRL, 32'h0000_0001);
      sync();
      drive_rate(mf, md);
      $display("test loop phase %0d done", p);
    end
    apb(1'b1, REG_CTRL, 32'h0000_0000);
    repeat (5) @(posedge clk);
    chk({30'h0, da, db}, 32'h0000_0000);
    apb(1'b1, REG_CTRL, 32'h0000_0001);
    rd(REG_FREQ, 32'h0005_5730);
    rd(REG_DUTY, 32'h0000_1388);
    $display("test restart done");
    conclude();
  end
endmodule : tb_inductive_tx_power_pid_control
`default_nettype wire

// ---- rtl/ipc_bridge_drive.sv ----
// full-bridge drive waveform generator from frequency and duty
`timescale 1ns/100ps
`default_nettype none
module ipc_bridge_drive
  import ipc_pkg::*;
(
  input  wire logic        i_clk_sys,
  input  wire logic        i_rstn,
  input  wire logic        i_enable,
  input  wire logic [18:0] i_freq,
  input  wire logic [13:0] i_duty,
  output var  logic        o_drive_a,
  output var  logic        o_drive_b
);

  typedef struct packed {
    logic [24:0] acc;
    logic        drive_a;
    logic        drive_b;
  } ipc_drv_st_t;

  ipc_drv_st_t st;
  ipc_drv_st_t next_st;
  logic [25:0] sum;
  logic [24:0] thr;

  // 10 MHz gives only ~49 clocks per cycle at 205 kHz; the modulo accumulator dithers
  // edges so average frequency and duty keep sub-clock resolution
  always_comb begin
    next_st = st;
    sum     = {1'b0, st.acc} + {7'h00, i_freq};
    thr     = i_duty * DUTY_TO_PHASE;
    if (!i_enable) begin
      next_st.acc = '0;
    end else if (sum >= {1'b0, ACC_MOD}) begin
      next_st.acc = 25'(sum - {1'b0, ACC_MOD});
    end else begin
      next_st.acc = sum[24:0];
    end
    next_st.drive_a = i_enable && (st.acc < thr);
    next_st.drive_b = i_enable && (st.acc >= ACC_HALF)
                      && ((st.acc - ACC_HALF) < thr);
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_drive_a = st.drive_a;
  assign o_drive_b = st.drive_b;

endmodule : ipc_bridge_drive
`default_nettype wire

// ---- rtl/ipc_pkg.sv ----
// constants, types and register map of the inductive power pid controller
// Functional notes
// - frequency mode keeps drive between 110 and 205 kHz at 50 percent duty
// - duty adjusts only at 205 kHz and stays within 10 to 50 percent
// - higher frequency or lower duty means less transferred power
// - frequency step finer than the banded resolution limits
// - duty cycle settable in 0.1 percent steps or finer
// - first power application starts at 175 kHz, 50 percent duty
// - controlled variable is frequency or duty, by operating region
// - coil current amplitude sensed at 7 mA or finer feeds the loop
// - frequency loop gains 10 and 0.05, integral 3000, output 20000
// - frequency change scaled 1.5, 2, 3 or 5 Hz by frequency band
// - duty loop same gains and limits, scaled -0.01 percent per unit
package ipc_pkg;

  // clock and loop period
  localparam int unsigned CLK_HZ       = 32'h0098_9680;
  localparam int unsigned US_PER_S     = 32'h000f_4240;
  localparam int unsigned TICK_TIME_US = 32'h0000_03e8;
  localparam int unsigned TICK_CYCLES  = TICK_TIME_US * (CLK_HZ / US_PER_S);

  // frequency in half-hertz units
  localparam logic [18:0] FREQ_MIN   = 19'h3_5b60;
  localparam logic [18:0] FREQ_MAX   = 19'h6_4190;
  localparam logic [18:0] FREQ_INIT  = 19'h5_5730;
  localparam logic [18:0] BAND_EDGE1 = 19'h4_45c0;
  localparam logic [18:0] BAND_EDGE2 = 19'h4_e200;
  localparam logic [18:0] BAND_EDGE3 = 19'h5_7e40;
  localparam int          SCALE_B0   = 32'h0000_0003;
  localparam int          SCALE_B1   = 32'h0000_0004;
  localparam int          SCALE_B2   = 32'h0000_0006;
  localparam int          SCALE_B3   = 32'h0000_000a;

  // duty in units of 0.01 percent
  localparam logic [13:0] DUTY_MIN   = 14'h03e8;
  localparam logic [13:0] DUTY_HALF  = 14'h1388;

  // pid constants; integral gain 0.05 is a divide by 20
  localparam int PROP_GAIN   = 32'h0000_000a;
  localparam int INTEG_DIV   = 32'h0000_0014;
  localparam int INTEG_LIMIT = 32'h0000_0bb8;
  localparam int OUT_LIMIT   = 32'h0000_4e20;

  // drive phase accumulator, modulus equals clock rate in half-hertz
  localparam logic [24:0] ACC_MOD       = 25'h131_2d00;
  localparam logic [24:0] ACC_HALF      = 25'h098_9680;
  localparam logic [24:0] DUTY_TO_PHASE = 25'h000_07d0;

  // register offsets
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_TARGET   = 8'h04;
  localparam logic [7:0] REG_FREQ     = 8'h08;
  localparam logic [7:0] REG_DUTY     = 8'h0c;
  localparam logic [7:0] REG_STATUS   = 8'h10;
  localparam logic [7:0] REG_COIL     = 8'h14;
  localparam logic [7:0] REG_LOOP_OUT = 8'h18;

  // fields and reset values
  localparam int          CTRL_PWR_BIT  = 0;
  localparam int          CTRL_LOOP_BIT = 1;
  localparam int          STAT_DUTY_BIT = 0;
  localparam int          STAT_DRV_BIT  = 1;
  localparam logic [1:0]  CTRL_RESET    = 2'h0;
  localparam logic [11:0] TARGET_RESET  = 12'h000;

  typedef enum logic [1:0] {
    IPC_MODE_FREQ = 2'b01,
    IPC_MODE_DUTY = 2'b10
  } ipc_mode_t;

endpackage : ipc_pkg

// ---- rtl/ipc_power_ctrl.sv ----
// pid power controller with apb registers and full-bridge drive
//
// Chosen here: register access over APB and the address map.
`timescale 1ns/100ps
`default_nettype none
module ipc_power_ctrl
  import ipc_pkg::*;
#(
  parameter int unsigned P_TICK_CYCLES = TICK_CYCLES
) (
  input  wire logic        i_clk_sys,
  input  wire logic        i_rstn,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  input  wire logic [11:0] i_coil_ma,
  output var  logic [31:0] o_prdata,
  output var  logic        o_pready,
  output var  logic        o_pslverr,
  output var  logic        o_drive_a,
  output var  logic        o_drive_b
);

  if (P_TICK_CYCLES < 2 || P_TICK_CYCLES > 65535) begin : g_bad_tick
    $error("tick count out of range");
  end

  typedef struct packed {
    logic               ctrl_pwr;
    logic               ctrl_loop;
    logic               pwr_d;
    logic [11:0]        target;
    logic [15:0]        tick_cnt;
    logic [18:0]        freq;
    logic [13:0]        duty;
    ipc_mode_t          mode;
    logic signed [17:0] integ;
    logic signed [17:0] last_out;
    logic [31:0]        rdata;
    logic               pready;
    logic               pslverr;
  } ipc_state_t;

  ipc_state_t st;
  ipc_state_t next_st;

  logic tick;
  logic pwr_rise;
  logic loop_go;
  int   err;
  int   integ_sum;
  int   pid_out;
  int   freq_new;
  int   duty_new;

  function automatic int sat(input int v, input int lim);
    if (v > lim) begin
      return lim;
    end else if (v < -lim) begin
      return -lim;
    end
    return v;
  endfunction : sat

  function automatic int band_scale(input logic [18:0] f);
    if (f < BAND_EDGE1) begin
      return SCALE_B0;
    end else if (f < BAND_EDGE2) begin
      return SCALE_B1;
    end else if (f < BAND_EDGE3) begin
      return SCALE_B2;
    end
    return SCALE_B3;
  endfunction : band_scale

  // one pid update per millisecond, the unit of the integral gain
  assign tick     = (st.tick_cnt == 16'(P_TICK_CYCLES - 1));
  assign pwr_rise = st.ctrl_pwr && !st.pwr_d;
  assign loop_go  = tick && st.ctrl_pwr && st.pwr_d && st.ctrl_loop;

  // derivative gain is zero, so no derivative path is built
  assign err       = int'(st.target) - int'(i_coil_ma);
  assign integ_sum = sat(int'(st.integ) + err,
                         INTEG_LIMIT * INTEG_DIV);
  assign pid_out   = sat(PROP_GAIN * err + integ_sum / INTEG_DIV,
                         OUT_LIMIT);
  // positive output asks for more power: frequency falls, duty rises
  assign freq_new  = int'(st.freq) - pid_out * band_scale(st.freq);
  assign duty_new  = int'(st.duty) + pid_out;

  always_comb begin
    next_st        = st;
    next_st.pwr_d  = st.ctrl_pwr;
    next_st.pready = 1'b0;

    if (!st.ctrl_pwr || pwr_rise || tick) begin
      next_st.tick_cnt = '0;
    end else begin
      next_st.tick_cnt = st.tick_cnt + 16'h0001;
    end

    if (pwr_rise) begin
      next_st.freq  = FREQ_INIT;
      next_st.duty  = DUTY_HALF;
      next_st.mode  = IPC_MODE_FREQ;
      next_st.integ = '0;
    end else if (loop_go) begin
      next_st.integ    = 18'(integ_sum);
      next_st.last_out = 18'(pid_out);
      case (st.mode)
        IPC_MODE_FREQ: begin
          next_st.duty = DUTY_HALF;
          if (freq_new > int'(FREQ_MAX)) begin
            next_st.freq = FREQ_MAX;
            if (pid_out < 0) begin
              next_st.mode = IPC_MODE_DUTY;
            end
          end else if (freq_new < int'(FREQ_MIN)) begin
            next_st.freq = FREQ_MIN;
          end else begin
            next_st.freq = 19'(freq_new);
          end
        end
        IPC_MODE_DUTY: begin
          next_st.freq = FREQ_MAX;
          if (duty_new >= int'(DUTY_HALF)) begin
            next_st.duty = DUTY_HALF;
            next_st.mode = IPC_MODE_FREQ;
          end else if (duty_new < int'(DUTY_MIN)) begin
            next_st.duty = DUTY_MIN;
          end else begin
            next_st.duty = 14'(duty_new);
          end
        end
        default: begin
          next_st.mode = IPC_MODE_FREQ;
        end
      endcase
    end

    // apb setup: decode and latch the answer for the access phase
    if (i_psel && !i_penable) begin
      next_st.pready  = 1'b1;
      next_st.pslverr = 1'b0;
      next_st.rdata   = '0;
      if (i_paddr == REG_CTRL) begin
        next_st.rdata[CTRL_PWR_BIT]  = st.ctrl_pwr;
        next_st.rdata[CTRL_LOOP_BIT] = st.ctrl_loop;
      end else if (i_paddr == REG_TARGET) begin
        next_st.rdata[11:0] = st.target;
      end else if (i_paddr == REG_FREQ) begin
        next_st.rdata[18:0] = st.freq;
      end else if (i_paddr == REG_DUTY) begin
        next_st.rdata[13:0] = st.duty;
      end else if (i_paddr == REG_STATUS) begin
        next_st.rdata[STAT_DUTY_BIT] = (st.mode == IPC_MODE_DUTY);
        next_st.rdata[STAT_DRV_BIT]  = st.pwr_d;
      end else if (i_paddr == REG_COIL) begin
        next_st.rdata[11:0] = i_coil_ma;
      end else if (i_paddr == REG_LOOP_OUT) begin
        next_st.rdata = 32'(st.last_out);
      end else begin
        next_st.pslverr = 1'b1;
      end
    end

    // apb access: writes land on the completing edge only
    if (i_psel && i_penable && st.pready && i_pwrite) begin
      if (i_paddr == REG_CTRL) begin
        next_st.ctrl_pwr  = i_pwdata[CTRL_PWR_BIT];
        next_st.ctrl_loop = i_pwdata[CTRL_LOOP_BIT];
      end else if (i_paddr == REG_TARGET) begin
        next_st.target = i_pwdata[11:0];
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      st           <= '0;
      st.ctrl_pwr  <= CTRL_RESET[CTRL_PWR_BIT];
      st.ctrl_loop <= CTRL_RESET[CTRL_LOOP_BIT];
      st.target    <= TARGET_RESET;
      st.freq      <= FREQ_INIT;
      st.duty      <= DUTY_HALF;
      st.mode      <= IPC_MODE_FREQ;
    end else begin
      st <= next_st;
    end
  end

  // bridge drive runs one cycle after the start values are loaded
  ipc_bridge_drive u_drive (
    .i_clk_sys (i_clk_sys),
    .i_rstn    (i_rstn),
    .i_enable  (st.pwr_d),
    .i_freq    (st.freq),
    .i_duty    (st.duty),
    .o_drive_a (o_drive_a),
    .o_drive_b (o_drive_b)
  );

  assign o_prdata  = st.rdata;
  assign o_pready  = st.pready;
  assign o_pslverr = st.pslverr;

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rstn);

  a_freq_range: assert property (
    st.freq >= FREQ_MIN && st.freq <= FREQ_MAX)
    else $error("drive frequency out of range");

  a_freq_mode_duty: assert property (
    st.mode == IPC_MODE_FREQ |-> st.duty == DUTY_HALF)
    else $error("duty not half in frequency mode");

  a_duty_at_top: assert property (
    st.mode == IPC_MODE_DUTY |-> st.freq == FREQ_MAX
      && st.duty >= DUTY_MIN && st.duty <= DUTY_HALF)
    else $error("duty mode away from top frequency");

  a_power_start: assert property (
    pwr_rise |=> (st.freq == FREQ_INIT && st.duty == DUTY_HALF
      && st.mode == IPC_MODE_FREQ) ##1 (o_drive_a && !o_drive_b))
    else $error("bad start values");

  a_freq_direction: assert property (
    loop_go && st.mode == IPC_MODE_FREQ && pid_out > 0
      && st.freq > FREQ_MIN |=> st.freq < $past(st.freq))
    else $error("frequency did not fall on power demand");

  a_duty_direction: assert property (
    loop_go && st.mode == IPC_MODE_DUTY && pid_out < 0
      && st.duty > DUTY_MIN |=> st.duty < $past(st.duty))
    else $error("duty did not fall on power cut");

  a_pid_limits: assert property (
    loop_go |=> st.integ <= 18'(INTEG_LIMIT * INTEG_DIV)
      && st.integ >= -18'(INTEG_LIMIT * INTEG_DIV)
      && st.last_out <= 18'(OUT_LIMIT) && st.last_out >= -18'(OUT_LIMIT))
    else $error("pid term beyond limit");

  a_mode_enter: assert property (
    st.mode == IPC_MODE_DUTY && $past(st.mode) == IPC_MODE_FREQ
      |-> $past(pid_out) < 0 && st.freq == FREQ_MAX)
    else $error("duty mode entered without cut at top");

  a_mode_leave: assert property (
    st.mode == IPC_MODE_FREQ && $past(st.mode) == IPC_MODE_DUTY
      |-> st.duty == DUTY_HALF)
    else $error("frequency mode resumed below half duty");

  a_apb_ready: assert property (
    i_psel && !i_penable |=> o_pready ##1 !o_pready)
    else $error("apb answer not one access cycle");

  a_drive_apart: assert property (
    o_drive_a |-> !o_drive_b)
    else $error("both bridge legs on");

  a_drive_idle: assert property (
    !st.pwr_d |=> !o_drive_a && !o_drive_b)
    else $error("bridge driven before start values");

  a_hold_values: assert property (
    !loop_go && !pwr_rise |=> $stable(st.freq) && $stable(st.duty)
      && $stable(st.mode))
    else $error("operating point moved without update");

  a_integ_clear: assert property (
    pwr_rise |=> st.integ == '0)
    else $error("integral not cleared at start");

  a_leave_demand: assert property (
    loop_go && st.mode == IPC_MODE_DUTY |=> st.mode == IPC_MODE_DUTY
      || $past(pid_out) >= 0)
    else $error("duty mode left without power demand");

  a_status_read: assert property (
    i_psel && !i_penable && i_paddr == REG_STATUS
      |=> o_prdata[STAT_DUTY_BIT] == ($past(st.mode) == IPC_MODE_DUTY))
    else $error("status mode bit wrong");

  // register bus checks; answers are latched at the setup edge
  a_apb_error: assert property (
    i_psel && !i_penable && (i_paddr[1:0] != 2'h0 || i_paddr > REG_LOOP_OUT)
      |=> o_pslverr && o_prdata == '0)
    else $error("unmapped address not refused");

  a_apb_read_freq: assert property (
    i_psel && !i_penable && i_paddr == REG_FREQ
      |=> o_prdata == 32'($past(st.freq)))
    else $error("frequency read back wrong");

  a_target_write: assert property (
    i_psel && i_penable && o_pready && i_pwrite && i_paddr == REG_TARGET
      |=> st.target == $past(i_pwdata[11:0]))
    else $error("target write lost");

endmodule : ipc_power_ctrl
`default_nettype wire
